// >>> shared/puhc_regs.svh
// register offsets, field positions and reset values of the unit header codec
`ifndef PUHC_REGS_SVH
`define PUHC_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PUHC_OFF_CTRL    8'h00
`define PUHC_OFF_CTX     8'h04
`define PUHC_OFF_STAT    8'h08
`define PUHC_OFF_ERR     8'h0C
`define PUHC_OFF_UNITS   8'h10

// ----------------------------------------
// field positions
// ----------------------------------------
`define PUHC_CTRL_EN         0
`define PUHC_CTRL_XMAP       1
`define PUHC_CTRL_HLBL_LSB   4
`define PUHC_CTRL_CLBL_LSB   8
`define PUHC_CTRL_MAX_LSB    16
`define PUHC_CTX_RA          0
`define PUHC_CTX_TDM         1
`define PUHC_CTX_STAR        2
`define PUHC_CTX_SIGDED      3
`define PUHC_CTX_CONT_LSB    4
`define PUHC_STAT_BUSY       8
`define PUHC_ERR_ZERO        0
`define PUHC_ERR_MAX         1
`define PUHC_ERR_SLOT        2
`define PUHC_ERR_SHORT       3

// ----------------------------------------
// reset values and sizes
// ----------------------------------------
`define PUHC_CTRL_RESET      32'h0FFF0000
`define PUHC_CTX_RESET       32'h00000000
`define PUHC_MIN_START_LEN   11'h002
`define PUHC_LEN_W           11
`define PUHC_TOTAL_W         12
`define PUHC_SLOTS           8

`endif

// >>> shared/puhc_pkg.sv
// types of the unit header codec
package puhc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HDR1,
        ST_LABEL,
        ST_HDR2,
        ST_PAY
    } puhc_state_t;

    typedef enum logic [1:0] {
        CONT_TRAFFIC,
        CONT_LOGON,
        CONT_CONTROL,
        CONT_OTHER
    } puhc_content_t;

endpackage

// >>> shared/puhc_unit_if.sv
// descriptor of the unit being framed, between sequencer and header packer
`timescale 1ns/1ps
interface puhc_unit_if;
    logic        start;
    logic        last;
    logic [10:0] len;
    logic [2:0]  slot;
    logic [1:0]  ltype;
    logic        supp;
    logic        use_crc;
    logic [11:0] total;
    logic [1:0]  idx;
    logic [7:0]  hdr_byte;

    modport src  (output start, last, len, slot, ltype, supp, use_crc, total, idx, input hdr_byte);
    modport pack (input start, last, len, slot, ltype, supp, use_crc, total, idx, output hdr_byte);
endinterface

// >>> hdl/puhc_hdr_pack.sv
// header byte packer for first and second unit header
`timescale 1ns/1ps
module puhc_hdr_pack (
    puhc_unit_if.pack u
);
    logic [2:0] tail;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;

    always_comb begin
        // full unit: label type and suppression; otherwise slot tag
        if (u.start && u.last) begin
            tail = {u.ltype, u.supp};
        end else begin
            tail = u.slot;
        end
        b0 = {u.start, u.last, u.len[10:5]};
        b1 = {u.len[4:0], tail};
        b2 = {u.use_crc, u.total[11:5]};
        b3 = {u.total[4:0], u.ltype, u.supp};
        case (u.idx)
            2'h0: u.hdr_byte = b0;
            2'h1: u.hdr_byte = b1;
            2'h2: u.hdr_byte = b2;
            default: u.hdr_byte = b3;
        endcase
    end
endmodule // puhc_hdr_pack

// >>> hdl/puhc_slot_track.sv
// per slot tag record of packets opened and not yet finalized
`timescale 1ns/1ps
`include "puhc_regs.svh"
module puhc_slot_track (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   open,
    input  wire logic                   close,
    input  wire logic [2:0]             slot,
    output logic [`PUHC_SLOTS-1:0]      busy
);
    logic [`PUHC_SLOTS-1:0] next_busy;

    genvar g;
    generate
        for (g = 0; g < `PUHC_SLOTS; g++) begin : g_slot
            always_comb begin
                next_busy[g] = busy[g];
                if (open && slot == 3'(g)) begin
                    next_busy[g] = 1'b1;
                end else if (close && slot == 3'(g)) begin
                    next_busy[g] = 1'b0;
                end
            end
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    busy[g] <= 1'b0;
                end else begin
                    busy[g] <= next_busy[g];
                end
            end
        end
    endgenerate
endmodule // puhc_slot_track

// >>> hdl/puhc_top.sv
// unit header codec: register slave and unit framing sequencer
//
// Added by the designer: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "puhc_regs.svh"
module puhc_top (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    // unit request
    input  wire logic        REQ_VALID,
    output logic             REQ_READY,
    input  wire logic        REQ_START,
    input  wire logic        REQ_END,
    input  wire logic [10:0] REQ_LEN,
    input  wire logic [2:0]  REQ_SLOT,
    input  wire logic [1:0]  REQ_LTYPE,
    input  wire logic        REQ_SUPP,
    input  wire logic        REQ_CRC,
    input  wire logic [11:0] REQ_TOTAL,
    output logic             REQ_REJECT,
    // packet bytes in
    input  wire logic [7:0]  PAY_DATA,
    input  wire logic        PAY_VALID,
    output logic             PAY_READY,
    // framed bytes out
    output logic [7:0]       OUT_DATA,
    output logic             OUT_VALID,
    output logic             OUT_SOF
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    puhc_pkg::puhc_state_t state;
    puhc_pkg::puhc_state_t next_state;
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [31:0] ctx;
    logic [31:0] next_ctx;
    logic [3:0]  err;
    logic [3:0]  next_err;
    logic [15:0] units;
    logic [15:0] next_units;
    logic [31:0] next_dat_o;
    logic        next_ack;
    logic [10:0] cnt;
    logic [10:0] next_cnt;
    logic        next_req_ready;
    logic        next_reject;
    logic        next_pay_ready;
    logic [7:0]  next_out_data;
    logic        next_out_valid;
    logic        next_out_sof;
    logic        d_start;
    logic        d_last;
    logic [10:0] d_len;
    logic [2:0]  d_slot;
    logic [1:0]  d_ltype;
    logic        d_supp;
    logic        d_crc;
    logic [11:0] d_total;
    logic [1:0]  d_idx;
    logic        next_d_start;
    logic        next_d_last;
    logic [10:0] next_d_len;
    logic [2:0]  next_d_slot;
    logic [1:0]  next_d_ltype;
    logic        next_d_supp;
    logic        next_d_crc;
    logic [11:0] next_d_total;
    logic [1:0]  next_d_idx;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic [7:0]  slot_busy;
    logic        slot_open;
    logic        slot_close;
    logic        wb_go;
    logic [31:0] wmask;
    logic [3:0]  lbl_cnt;
    logic        fmt_sig;
    logic [11:0] max_total;
    logic        accept;
    logic        is_pad;
    logic [3:0]  fault;

    puhc_unit_if u ();

    assign u.start   = d_start;
    assign u.last    = d_last;
    assign u.len     = d_len;
    assign u.slot    = d_slot;
    assign u.ltype   = d_ltype;
    assign u.supp    = d_supp;
    assign u.use_crc = d_crc;
    assign u.total   = d_total;
    assign u.idx     = d_idx;

    puhc_hdr_pack u_pack (
        .u (u.pack)
    );

    puhc_slot_track u_slots (
        .clk   (CLK),
        .rst   (RST),
        .open  (slot_open),
        .close (slot_close),
        .slot  (REQ_SLOT),
        .busy  (slot_busy)
    );

    // ----------------------------------------
    // context decode
    // ----------------------------------------
    always_comb begin
        max_total = ctrl[`PUHC_CTRL_MAX_LSB +: 12];
        // star contexts with the TDM bit clear carry no unit label, whatever the access kind
        if (ctx[`PUHC_CTX_STAR] && !ctx[`PUHC_CTX_TDM]) begin
            lbl_cnt = 4'h0;
        end else if (ctrl[`PUHC_CTRL_XMAP]) begin
            lbl_cnt = ctrl[`PUHC_CTRL_HLBL_LSB +: 4];
        end else begin
            lbl_cnt = ctrl[`PUHC_CTRL_CLBL_LSB +: 4];
        end
        // logon, control and other non-traffic content in a signalling frame carry bare SDU bytes
        fmt_sig = (ctx[`PUHC_CTX_CONT_LSB +: 2] != 2'(puhc_pkg::CONT_TRAFFIC))
                  && (ctx[`PUHC_CTX_SIGDED] || !ctx[`PUHC_CTX_RA]);
    end

    // ----------------------------------------
    // request checks
    // ----------------------------------------
    always_comb begin
        is_pad = !REQ_START && !REQ_END && (REQ_LEN == 11'h000);
        fault  = 4'h0;
        fault[`PUHC_ERR_ZERO]  = (REQ_START || REQ_END || fmt_sig) && (REQ_LEN == 11'h000);
        if (!fmt_sig) begin
            fault[`PUHC_ERR_SHORT] = REQ_START && !REQ_END && (REQ_LEN < `PUHC_MIN_START_LEN);
            fault[`PUHC_ERR_MAX]   = REQ_START && (REQ_END ? ({1'b0, REQ_LEN} > max_total)
                                                           : (REQ_TOTAL > max_total));
            fault[`PUHC_ERR_SLOT]  = (REQ_START && !REQ_END && slot_busy[REQ_SLOT])
                                     || (!REQ_START && !is_pad && !slot_busy[REQ_SLOT]);
        end
        accept     = REQ_VALID && REQ_READY && ctrl[`PUHC_CTRL_EN] && (fault == 4'h0);
        slot_open  = accept && !fmt_sig && REQ_START && !REQ_END;
        slot_close = accept && !fmt_sig && !REQ_START && REQ_END;
    end

    // ----------------------------------------
    // wishbone slave
    // ----------------------------------------
    always_comb begin
        wb_go      = WB_CYC_I && WB_STB_I && !WB_ACK_O;
        wmask      = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
        next_ack   = wb_go;
        next_ctrl  = ctrl;
        next_ctx   = ctx;
        next_dat_o = 32'h00000000;
        next_err   = err;
        if (WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I) begin
            if (WB_ADR_I == `PUHC_OFF_CTRL) begin
                next_ctrl = (ctrl & ~wmask) | (WB_DAT_I & wmask);
            end else if (WB_ADR_I == `PUHC_OFF_CTX) begin
                next_ctx = (ctx & ~wmask) | (WB_DAT_I & wmask);
            end else if (WB_ADR_I == `PUHC_OFF_ERR && WB_SEL_I[0]) begin
                next_err = err & ~WB_DAT_I[3:0];
            end
        end else if (wb_go && !WB_WE_I) begin
            if (WB_ADR_I == `PUHC_OFF_CTRL) begin
                next_dat_o = ctrl;
            end else if (WB_ADR_I == `PUHC_OFF_CTX) begin
                next_dat_o = ctx;
            end else if (WB_ADR_I == `PUHC_OFF_STAT) begin
                next_dat_o = {23'h000000, (state != puhc_pkg::ST_IDLE), slot_busy};
            end else if (WB_ADR_I == `PUHC_OFF_ERR) begin
                next_dat_o = {28'h0000000, err};
            end else if (WB_ADR_I == `PUHC_OFF_UNITS) begin
                next_dat_o = {16'h0000, units};
            end
        end
        // a refused request in the clearing cycle still sets its bit
        if (REQ_VALID && REQ_READY && ctrl[`PUHC_CTRL_EN]) begin
            next_err = next_err | fault;
        end
    end

    // ----------------------------------------
    // framing sequencer
    // ----------------------------------------
    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_units     = units;
        next_reject    = 1'b0;
        next_out_data  = 8'h00;
        next_out_valid = 1'b0;
        next_out_sof   = 1'b0;
        next_d_start   = d_start;
        next_d_last    = d_last;
        next_d_len     = d_len;
        next_d_slot    = d_slot;
        next_d_ltype   = d_ltype;
        next_d_supp    = d_supp;
        next_d_crc     = d_crc;
        next_d_total   = d_total;
        next_d_idx     = d_idx;
        case (state)
            puhc_pkg::ST_IDLE: begin
                if (REQ_VALID && REQ_READY) begin
                    if (accept) begin
                        next_d_start = REQ_START;
                        next_d_last  = REQ_END;
                        next_d_len   = REQ_LEN;
                        next_d_slot  = is_pad ? 3'h0 : REQ_SLOT;
                        next_d_ltype = REQ_LTYPE;
                        next_d_supp  = REQ_SUPP;
                        next_d_crc   = REQ_CRC;
                        next_d_total = REQ_TOTAL;
                        next_d_idx   = 2'h0;
                        if (!is_pad) begin
                            next_units = units + 16'h0001;
                        end
                        if (fmt_sig) begin
                            next_cnt   = REQ_LEN;
                            next_state = puhc_pkg::ST_PAY;
                        end else begin
                            next_state = puhc_pkg::ST_HDR1;
                        end
                    end else begin
                        next_reject = 1'b1;
                    end
                end
            end
            puhc_pkg::ST_HDR1: begin
                next_out_data  = u.hdr_byte;
                next_out_valid = 1'b1;
                next_out_sof   = (d_idx == 2'h0);
                next_d_idx     = d_idx + 2'h1;
                if (d_idx == 2'h1) begin
                    next_cnt = {7'h00, lbl_cnt};
                    if (d_len == 11'h000) begin
                        next_state = puhc_pkg::ST_IDLE;
                    end else if (lbl_cnt != 4'h0) begin
                        next_state = puhc_pkg::ST_LABEL;
                    end else if (d_start && !d_last) begin
                        next_state = puhc_pkg::ST_HDR2;
                    end else begin
                        next_cnt   = d_len;
                        next_state = puhc_pkg::ST_PAY;
                    end
                end
            end
            puhc_pkg::ST_LABEL: begin
                // label content is reserved, sent as zero
                next_out_valid = 1'b1;
                next_cnt       = cnt - 11'h001;
                if (cnt == 11'h001) begin
                    if (d_start && !d_last) begin
                        next_state = puhc_pkg::ST_HDR2;
                    end else begin
                        next_cnt   = d_len;
                        next_state = puhc_pkg::ST_PAY;
                    end
                end
            end
            puhc_pkg::ST_HDR2: begin
                next_out_data  = u.hdr_byte;
                next_out_valid = 1'b1;
                next_d_idx     = d_idx + 2'h1;
                if (d_idx == 2'h3) begin
                    next_cnt   = d_len - `PUHC_MIN_START_LEN;
                    next_state = (d_len == `PUHC_MIN_START_LEN) ? puhc_pkg::ST_IDLE : puhc_pkg::ST_PAY;
                end
            end
            puhc_pkg::ST_PAY: begin
                if (PAY_VALID && PAY_READY) begin
                    next_out_data  = PAY_DATA;
                    next_out_valid = 1'b1;
                    next_out_sof   = fmt_sig && (cnt == d_len);
                    next_cnt       = cnt - 11'h001;
                    if (cnt == 11'h001) begin
                        next_state = puhc_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                next_state = puhc_pkg::ST_IDLE;
            end
        endcase
        next_req_ready = (next_state == puhc_pkg::ST_IDLE);
        next_pay_ready = (next_state == puhc_pkg::ST_PAY) && (next_cnt != 11'h000);
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state      <= puhc_pkg::ST_IDLE;
            ctrl       <= `PUHC_CTRL_RESET;
            ctx        <= `PUHC_CTX_RESET;
            err        <= 4'h0;
            units      <= 16'h0000;
            cnt        <= 11'h000;
            WB_DAT_O   <= 32'h00000000;
            WB_ACK_O   <= 1'b0;
            REQ_READY  <= 1'b0;
            REQ_REJECT <= 1'b0;
            PAY_READY  <= 1'b0;
            OUT_DATA   <= 8'h00;
            OUT_VALID  <= 1'b0;
            OUT_SOF    <= 1'b0;
            d_start    <= 1'b0;
            d_last     <= 1'b0;
            d_len      <= 11'h000;
            d_slot     <= 3'h0;
            d_ltype    <= 2'h0;
            d_supp     <= 1'b0;
            d_crc      <= 1'b0;
            d_total    <= 12'h000;
            d_idx      <= 2'h0;
        end else begin
            state      <= next_state;
            ctrl       <= next_ctrl;
            ctx        <= next_ctx;
            err        <= next_err;
            units      <= next_units;
            cnt        <= next_cnt;
            WB_DAT_O   <= next_dat_o;
            WB_ACK_O   <= next_ack;
            REQ_READY  <= next_req_ready;
            REQ_REJECT <= next_reject;
            PAY_READY  <= next_pay_ready;
            OUT_DATA   <= next_out_data;
            OUT_VALID  <= next_out_valid;
            OUT_SOF    <= next_out_sof;
            d_start    <= next_d_start;
            d_last     <= next_d_last;
            d_len      <= next_d_len;
            d_slot     <= next_d_slot;
            d_ltype    <= next_d_ltype;
            d_supp     <= next_d_supp;
            d_crc      <= next_d_crc;
            d_total    <= next_d_total;
            d_idx      <= next_d_idx;
        end
    end

endmodule // puhc_top

// >>> verification/puhc_properties.sv
// assertions on the ports of the unit header codec
`timescale 1ns/1ps
module puhc_checker (
    // clock and reset
    input wire logic       CLK,
    input wire logic       RST,
    // observed ports
    input wire logic       WB_CYC_I,
    input wire logic       WB_STB_I,
    input wire logic       WB_ACK_O,
    input wire logic       REQ_VALID,
    input wire logic       REQ_READY,
    input wire logic       REQ_REJECT,
    input wire logic [7:0] PAY_DATA,
    input wire logic       PAY_VALID,
    input wire logic       PAY_READY,
    input wire logic [7:0] OUT_DATA,
    input wire logic       OUT_VALID,
    input wire logic       OUT_SOF
);
    // ----
    // checks
    // ----
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    property p_ack;
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not one pulse");
    property p_sof_fell;
        $fell(REQ_READY) |=> (OUT_SOF && OUT_VALID) || (PAY_READY && !OUT_VALID);
    endproperty
    a_sof_fell: assert property (p_sof_fell) else $error("no first byte");
    property p_sof_cont;
        OUT_SOF && !PAY_READY && !REQ_READY |=> OUT_VALID && !OUT_SOF;
    endproperty
    a_sof_cont: assert property (p_sof_cont) else $error("header split");
    property p_zero_len;
        OUT_SOF && !PAY_READY && !REQ_READY && OUT_DATA[7:6] != 2'h0 && OUT_DATA[5:0] == 6'h00
            |=> OUT_DATA[7:3] != 5'h00;
    endproperty
    a_zero_len: assert property (p_zero_len) else $error("zero length");
    property p_pad;
        OUT_SOF && !PAY_READY && !REQ_READY && OUT_DATA == 8'h00 ##1 OUT_DATA == 8'h00 |=> !OUT_VALID;
    endproperty
    a_pad: assert property (p_pad) else $error("bytes after padding");
    property p_rej_cause;
        REQ_REJECT |-> $past(REQ_VALID) && $past(REQ_READY);
    endproperty
    a_rej_cause: assert property (p_rej_cause) else $error("stray reject");
    property p_pay_out;
        PAY_VALID && PAY_READY |=> OUT_VALID && OUT_DATA == $past(PAY_DATA);
    endproperty
    a_pay_out: assert property (p_pay_out) else $error("byte lost");
    property p_busy_out;
        OUT_VALID && REQ_READY |=> !OUT_VALID;
    endproperty
    a_busy_out: assert property (p_busy_out) else $error("ready while sending");
    c_rej: cover property (REQ_REJECT);
    c_pad: cover property (OUT_SOF && OUT_DATA == 8'h00 ##1 OUT_DATA == 8'h00);
    c_pay: cover property (PAY_VALID && PAY_READY);
endmodule // puhc_checker
bind puhc_top puhc_checker u_chk (.CLK, .RST, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .REQ_VALID,
    .REQ_READY, .REQ_REJECT, .PAY_DATA, .PAY_VALID, .PAY_READY, .OUT_DATA, .OUT_VALID, .OUT_SOF);

// >>> verification/puhc_pay_src.sv
// packet byte source behind the payload input
`timescale 1ns/1ps
module puhc_pay_src (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // pacing and handshake
    input  wire logic       slow,
    input  wire logic       pay_ready,
    output logic            pay_valid,
    output logic      [7:0] pay_data
);
    logic [7:0] cnt;
    // offered byte held until taken, released line shows inverse
    assign pay_data = pay_valid ? cnt : ~cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt       <= 8'h00;
            pay_valid <= 1'b0;
        end else begin
            if (pay_valid && pay_ready) begin
                cnt <= cnt + 8'h01;
            end
            pay_valid <= (pay_valid && !pay_ready) || !slow || !pay_valid;
        end
    end
endmodule // puhc_pay_src

// >>> verification/tb.sv
// self-checking bench of the unit header codec
`timescale 1ns/1ps
`include "puhc_regs.svh"
module tb;
    typedef struct packed {
        logic        rej;
        logic [15:0] hdr;
        logic [31:0] f;
    } puhc_row_t;
    logic        CLK, RST, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, slow;
    logic [7:0]  WB_ADR_I, PAY_DATA, OUT_DATA;
    logic [3:0]  WB_SEL_I;
    logic [31:0] WB_DAT_I, WB_DAT_O, rd;
    logic        REQ_VALID, REQ_READY, REQ_START, REQ_END, REQ_SUPP, REQ_CRC, REQ_REJECT;
    logic [10:0] REQ_LEN;
    logic [2:0]  REQ_SLOT;
    logic [1:0]  REQ_LTYPE;
    logic [11:0] REQ_TOTAL;
    logic        PAY_VALID, PAY_READY, OUT_VALID, OUT_SOF;
    logic [7:0]  q[$];
    int          fails, tests_run;
    int          extra = 0;
    // start, end, stray continuation, full, padding, zero full, short start, long full
    puhc_row_t   rows [8] = '{'{1'h0, 16'h8021, 32'h8021100A}, '{1'h0, 16'h4019, 32'h40190000},
        '{1'h1, 16'h0000, 32'h001A0000}, '{1'h0, 16'hC013, 32'hC0106000},
        '{1'h0, 16'h0000, 32'h00000000}, '{1'h1, 16'h0000, 32'hC0000000},
        '{1'h1, 16'h0000, 32'h800B0000}, '{1'h0, 16'hC204, 32'hC2008000}};
    puhc_top u_dut (.CLK, .RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I,
        .WB_DAT_O, .WB_ACK_O, .REQ_VALID, .REQ_READY, .REQ_START, .REQ_END, .REQ_LEN, .REQ_SLOT,
        .REQ_LTYPE, .REQ_SUPP, .REQ_CRC, .REQ_TOTAL, .REQ_REJECT, .PAY_DATA, .PAY_VALID,
        .PAY_READY, .OUT_DATA, .OUT_VALID, .OUT_SOF);
    puhc_pay_src u_src (.clk(CLK), .rst(RST), .slow, .pay_ready(PAY_READY),
        .pay_valid(PAY_VALID), .pay_data(PAY_DATA));
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        if (OUT_VALID === 1'b1) q.push_back(OUT_DATA);
    end
    // ----
    // tasks
    // ----
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge CLK);
        {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I} <= {2'h3, we, a, 4'hF, d};
        for (i = 0; i < 20; i++) begin
            @(posedge CLK);
            if (WB_ACK_O === 1'b1) break;
        end
        rd = WB_DAT_O;
        {WB_CYC_I, WB_STB_I} <= 2'h0;
        if (i == 20) begin
            fails++;
            summarize();
        end
    endtask
    task automatic unit(input puhc_row_t r);
        int i, j;
        @(posedge CLK);
        q.delete();
        REQ_VALID <= 1'b1;
        {REQ_START, REQ_END, REQ_LEN, REQ_SLOT, REQ_LTYPE, REQ_SUPP, REQ_CRC, REQ_TOTAL} <= r.f;
        for (i = 0; i < 300; i++) begin
            @(posedge CLK);
            if (REQ_READY === 1'b1) break;
        end
        REQ_VALID <= 1'b0;
        @(posedge CLK);
        chk("reject", {31'h0, r.rej}, {31'h0, REQ_REJECT});
        for (j = 0; j < 300 && REQ_READY !== 1'b1; j++) begin
            @(posedge CLK);
        end
        if (i == 300 || j == 300) begin
            fails++;
            summarize();
        end
        repeat (2) @(posedge CLK);
        chk("bytes", r.rej ? 32'h0 : 32'h2 + extra + r.f[29:19], q.size());
        if (!r.rej && extra >= 0) chk("header", {16'h0, r.hdr}, {16'h0, q[0], q[1]});
        if (!r.rej && extra >= 0 && r.f[31:30] == 2'h2)
            chk("second header", {16'h0, r.f[12:0], r.f[15:13]}, {16'h0, q[2 + extra], q[3 + extra]});
    endtask
    // ----
    // sequence
    // ----
    initial begin
        {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I, REQ_VALID} = '0;
        {REQ_START, REQ_END, REQ_LEN, REQ_SLOT, REQ_LTYPE, REQ_SUPP, REQ_CRC, REQ_TOTAL} = '0;
        {slow, RST} = 2'h1;
        repeat (3) @(posedge CLK);
        chk("ready in reset", 32'h0, {31'h0, REQ_READY});
        RST <= 1'b0;
        repeat (2) @(posedge CLK);
        wb(1'b0, `PUHC_OFF_CTRL, 32'h0);
        chk("ctrl reset", `PUHC_CTRL_RESET, rd);
        REQ_VALID <= 1'b1;
        repeat (3) @(posedge CLK);
        REQ_VALID <= 1'b0;
        repeat (2) @(posedge CLK);
        chk("idle when off", 32'h1, {31'h0, REQ_READY});
        chk("silent when off", 32'h0, q.size());
        wb(1'b1, `PUHC_OFF_CTRL, `PUHC_CTRL_RESET | 32'h1);
        for (int k = 0; k < 8; k++) begin
            slow <= k[0];
            unit(rows[k]);
            $display("test %0d done", k);
        end
        wb(1'b0, `PUHC_OFF_ERR, 32'h0);
        chk("err", 32'h0000000D, rd);
        wb(1'b1, `PUHC_OFF_ERR, 32'h0000000F);
        wb(1'b0, `PUHC_OFF_ERR, 32'h0);
        chk("err clear", 32'h0, rd);
        wb(1'b0, `PUHC_OFF_UNITS, 32'h0);
        chk("units", 32'h4, rd);
        wb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("registers done");
        wb(1'b1, `PUHC_OFF_CTRL, `PUHC_CTRL_RESET | 32'h00000201);
        extra = 2;
        unit(rows[0]);
        chk("label byte", 32'h0, {24'h0, q[2]});
        unit(rows[1]);
        wb(1'b1, `PUHC_OFF_CTRL, `PUHC_CTRL_RESET | 32'h00000233);
        extra = 3;
        unit(rows[3]);
        wb(1'b1, `PUHC_OFF_CTX, 32'h00000004);
        extra = 0;
        unit(rows[3]);
        wb(1'b1, `PUHC_OFF_CTX, 32'h00000010);
        extra = -2;
        unit(rows[1]);
        extra = 0;
        $display("context tests done");
        RST <= 1'b1;
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        repeat (2) @(posedge CLK);
        chk("ready after reset", 32'h1, {31'h0, REQ_READY});
        wb(1'b0, `PUHC_OFF_UNITS, 32'h0);
        chk("units after reset", 32'h0, rd);
        $display("reset test done");
        summarize();
    end
endmodule // tb
